// ---- include/jts_pkg.sv ----
// constants, types and decode helpers for the test access port block
package jts_pkg;
    // chain widths
    localparam int IR_W = 4;
    localparam int BSR_W = 8;
    localparam int USR_W = 8;
    localparam int ID_W = 32;

    // instruction codes
    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_INTEST = 4'h1;
    localparam logic [3:0] INS_SAMPLE = 4'h2;
    localparam logic [3:0] INS_USER = 4'h3;
    localparam logic [3:0] INS_ABORT = 4'h8;
    localparam logic [3:0] INS_DPACC = 4'ha;
    localparam logic [3:0] INS_APACC = 4'hb;
    localparam logic [3:0] INS_IDCODE = 4'he;
    localparam logic [3:0] INS_BYPASS = 4'hf;

    // capture and reset values
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_RESET = INS_IDCODE;
    // identity word: value is arbitrary, bit 0 set as the usual marker
    localparam logic [31:0] IDCODE_VAL = 32'h0a5c_3001;
    localparam logic [7:0] BSR_RESET = 8'h00;
    localparam logic [7:0] USR_RESET = 8'h00;
    localparam logic BYP_CAPTURE = 1'b0;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // tap controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } jts_state_type;

    // data chain chosen by the current instruction
    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_IDCODE, SEL_BSR, SEL_USER, SEL_CORE, SEL_HOLD
    } jts_sel_type;

    // serial output with its enable
    typedef struct packed {
        logic tdo;
        logic oe;
    } jts_tdo_type;

    // per-chain strobes
    typedef struct packed {
        logic cap;
        logic shf;
        logic upd;
    } jts_ctl_type;

    // unknown codes fall back to the bypass chain
    function automatic jts_sel_type jts_decode(input logic [3:0] ins);
        unique case (ins)
            INS_EXTEST, INS_INTEST: jts_decode = SEL_HOLD;
            INS_SAMPLE: jts_decode = SEL_BSR;
            INS_USER: jts_decode = SEL_USER;
            INS_ABORT, INS_DPACC, INS_APACC: jts_decode = SEL_CORE;
            INS_IDCODE: jts_decode = SEL_IDCODE;
            default: jts_decode = SEL_BYPASS;
        endcase
    endfunction
endpackage

// ---- core/jts_chain.sv ----
// serial shift chain with parallel update register
`timescale 1ns/1ps
`default_nettype none
module jts_chain #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic tck,
    input wire logic rst_n,
    input wire jts_pkg::jts_ctl_type ctl,
    input wire logic clr,
    input wire logic tdi,
    input wire logic [WIDTH-1:0] cap_val,
    output logic so,
    output logic [WIDTH-1:0] par
);
    import jts_pkg::*;

    logic [WIDTH-1:0] sh_q, sh_d; // shift stage
    logic [WIDTH-1:0] par_q, par_d; // update stage

    // next values of both stages
    always_comb begin
        sh_d = sh_q;
        par_d = par_q;
        if (ctl.cap) begin
            sh_d = cap_val;
        end else if (ctl.shf) begin
            // new bit enters at the far end, lsb leaves first
            sh_d = {tdi, sh_q[WIDTH-1:1]};
        end
        if (clr) begin
            par_d = RST_VAL;
        end else if (ctl.upd) begin
            par_d = sh_q;
        end
    end

    // registers hold while tck stands still
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= RST_VAL;
            par_q <= RST_VAL;
        end else begin
            sh_q <= sh_d;
            par_q <= par_d;
        end
    end

    assign so = sh_q[0];
    assign par = par_q;
endmodule
`default_nettype wire

// ---- core/jts_tap.sv ----
// test access port controller with instruction and data chains
// Summary of operation
// - state follows test reset and sampled mode-select
// - state picks chain and capture, shift, update
// - held instruction selects the data chain
// - hold-type instructions touch no chain
// - unknown instruction codes act as bypass
// - test reset forces and holds reset state
// - reset state loads identity instruction
// - power-on reset also resets the controller
// - stopped test clock keeps state and data
// - five high mode-select cycles reach reset
// - data input sampled on rising edge
// - data output changes on falling edge
// - data output driven only while shifting
// - capture loads chain, shift moves bits through
// - update copies chain into parallel register
// - instruction chain is four bits wide
// - output muxed with core debug port
`timescale 1ns/1ps
`default_nettype none
module jts_tap (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output jts_pkg::jts_tdo_type tdo_out,
    input wire logic core_tdo,
    output logic core_sel,
    input wire logic [jts_pkg::BSR_W-1:0] pin_in,
    output logic [jts_pkg::BSR_W-1:0] pin_out,
    output logic pin_oe,
    output logic [jts_pkg::BSR_W-1:0] core_test_val,
    output logic core_test_en,
    output logic [jts_pkg::USR_W-1:0] user_word,
    output logic user_valid
);
    import jts_pkg::*;

    // system side power-on reset marker
    logic por_q, por_d;
    // reset release synchroniser in the tck domain
    logic [1:0] rsync_q, rsync_d;
    logic tap_rst_n; // combined async reset for the tap
    logic raw_rst_n; // unsynchronised reset term
    // controller state
    jts_state_type st_q, st_d;
    // decoded chain and strobes
    jts_sel_type sel;
    jts_ctl_type ir_ctl, bsr_ctl, usr_ctl;
    logic in_reset;
    logic shifting;
    // chain taps
    logic ir_so, bsr_so, usr_so;
    logic [IR_W-1:0] ir_par;
    logic [BSR_W-1:0] bsr_par;
    logic [USR_W-1:0] usr_par;
    // bypass and identity chains
    logic byp_q, byp_d;
    logic [ID_W-1:0] id_q, id_d;
    // pin sampler, two stages
    logic [BSR_W-1:0] pin_s1_q, pin_s2_q;
    logic [BSR_W-1:0] pin_s1_d, pin_s2_d;
    // update event toggle for the system side
    logic tgl_q, tgl_d;
    // falling edge output stage
    jts_tdo_type tdo_q, tdo_d;
    // system side toggle synchroniser and edge stage
    logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
    logic [2:0] tsync_d;
    logic [USR_W-1:0] word_q, word_d;
    logic valid_q, valid_d;

    // power-on marker follows the system reset
    always_comb begin
        por_d = srst;
    end

    always_ff @(posedge clk_sys) begin
        por_q <= por_d;
    end

    // either reset asserts at once, release is timed to tck
    assign raw_rst_n = trst_n & ~por_q;

    always_comb begin
        rsync_d = {rsync_q[0], 1'b1};
    end

    always_ff @(posedge tck or negedge raw_rst_n) begin
        if (!raw_rst_n) begin
            rsync_q <= SYNC_RESET;
        end else begin
            rsync_q <= rsync_d;
        end
    end

    assign tap_rst_n = rsync_q[1];

    // next state from current state and sampled mode-select
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RESET: st_d = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: st_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: st_d = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: st_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: st_d = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: st_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: st_d = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: st_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: st_d = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: st_d = tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // state only moves on a tck rise, so a parked clock freezes it
    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // chain selection and strobes
    always_comb begin
        sel = jts_decode(ir_par);
        in_reset = (st_q == ST_RESET);
        shifting = (st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR);
        // instruction path
        ir_ctl.cap = (st_q == ST_CAP_IR);
        ir_ctl.shf = (st_q == ST_SHIFT_IR);
        ir_ctl.upd = (st_q == ST_UPD_IR);
        // boundary chain, used only by sample
        bsr_ctl.cap = (st_q == ST_CAP_DR) && (sel == SEL_BSR);
        bsr_ctl.shf = (st_q == ST_SHIFT_DR) && (sel == SEL_BSR);
        bsr_ctl.upd = (st_q == ST_UPD_DR) && (sel == SEL_BSR);
        // user chain
        usr_ctl.cap = (st_q == ST_CAP_DR) && (sel == SEL_USER);
        usr_ctl.shf = (st_q == ST_SHIFT_DR) && (sel == SEL_USER);
        usr_ctl.upd = (st_q == ST_UPD_DR) && (sel == SEL_USER);
    end

    // four-bit instruction chain, cleared to the identity code in reset
    jts_chain #(
        .WIDTH(IR_W),
        .RST_VAL(IR_RESET)
    ) u_ir (
        .tck(tck),
        .rst_n(tap_rst_n),
        .ctl(ir_ctl),
        .clr(in_reset),
        .tdi(tdi),
        .cap_val(IR_CAPTURE),
        .so(ir_so),
        .par(ir_par)
    );

    // boundary chain, holds its update value for extest and intest
    jts_chain #(
        .WIDTH(BSR_W),
        .RST_VAL(BSR_RESET)
    ) u_bsr (
        .tck(tck),
        .rst_n(tap_rst_n),
        .ctl(bsr_ctl),
        .clr(1'b0),
        .tdi(tdi),
        .cap_val(pin_s2_q),
        .so(bsr_so),
        .par(bsr_par)
    );

    // user word chain, capture reads back the last update
    jts_chain #(
        .WIDTH(USR_W),
        .RST_VAL(USR_RESET)
    ) u_usr (
        .tck(tck),
        .rst_n(tap_rst_n),
        .ctl(usr_ctl),
        .clr(1'b0),
        .tdi(tdi),
        .cap_val(usr_par),
        .so(usr_so),
        .par(usr_par)
    );

    // bypass and identity chains, no update stage
    always_comb begin
        byp_d = byp_q;
        id_d = id_q;
        if (st_q == ST_CAP_DR && sel == SEL_BYPASS) begin
            byp_d = BYP_CAPTURE;
        end else if (st_q == ST_SHIFT_DR && sel == SEL_BYPASS) begin
            byp_d = tdi;
        end
        if (st_q == ST_CAP_DR && sel == SEL_IDCODE) begin
            id_d = IDCODE_VAL;
        end else if (st_q == ST_SHIFT_DR && sel == SEL_IDCODE) begin
            id_d = {tdi, id_q[ID_W-1:1]};
        end
    end

    // hold instructions leave both untouched
    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            byp_q <= BYP_CAPTURE;
            id_q <= IDCODE_VAL;
        end else begin
            byp_q <= byp_d;
            id_q <= id_d;
        end
    end

    // pins come from outside, two stages before the boundary capture
    always_comb begin
        pin_s1_d = pin_in;
        pin_s2_d = pin_s1_q;
    end

    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            pin_s1_q <= BSR_RESET;
            pin_s2_q <= BSR_RESET;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
        end
    end

    // each user update flips the toggle; word stays put until next update
    always_comb begin
        tgl_d = usr_ctl.upd ? ~tgl_q : tgl_q;
    end

    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tgl_q <= 1'b0;
        end else begin
            tgl_q <= tgl_d;
        end
    end

    // output mux: own chains, or the core port for its instructions
    always_comb begin
        tdo_d.oe = shifting;
        tdo_d.tdo = byp_q;
        if (st_q == ST_SHIFT_IR) begin
            tdo_d.tdo = ir_so;
        end else begin
            unique case (sel)
                SEL_BYPASS: tdo_d.tdo = byp_q;
                SEL_IDCODE: tdo_d.tdo = id_q[0];
                SEL_BSR: tdo_d.tdo = bsr_so;
                SEL_USER: tdo_d.tdo = usr_so;
                SEL_CORE: tdo_d.tdo = core_tdo;
                SEL_HOLD: tdo_d.tdo = byp_q;
            endcase
        end
    end

    // falling edge launch gives the next part a full half period
    always_ff @(negedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_q <= '0;
        end else begin
            tdo_q <= tdo_d;
        end
    end

    assign tdo_out = tdo_q;
    assign core_sel = (sel == SEL_CORE);

    // extest drives pins, intest drives the core, both from held data
    assign pin_out = bsr_par;
    assign pin_oe = (ir_par == INS_EXTEST);
    assign core_test_val = bsr_par;
    assign core_test_en = (ir_par == INS_INTEST);

    // system side: toggle through two stages, third for the edge
    always_comb begin
        tsync_d = {tgl_s2_q, tgl_s1_q, tgl_q};
        word_d = word_q;
        valid_d = 1'b0;
        // word is stable for several tck periods after the toggle
        if (tgl_s3_q != tgl_s2_q) begin
            word_d = usr_par;
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            word_q <= USR_RESET;
            valid_q <= 1'b0;
        end else begin
            tgl_s1_q <= tsync_d[0];
            tgl_s2_q <= tsync_d[1];
            tgl_s3_q <= tsync_d[2];
            word_q <= word_d;
            valid_q <= valid_d;
        end
    end

    assign user_word = word_q;
    assign user_valid = valid_q;
endmodule
`default_nettype wire

// ---- verif/jts_tap_props.sv ----
// assertions on the test access port outputs
`timescale 1ns/1ps
`default_nettype none
module jts_tap_props (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire jts_pkg::jts_tdo_type tdo_out,
    input wire logic core_sel,
    input wire logic pin_oe,
    input wire logic core_test_en,
    input wire logic [jts_pkg::USR_W-1:0] user_word,
    input wire logic user_valid
);
    import jts_pkg::*;
    // five rising edges with mode-select high
    sequence s_five_high;
        tms [*5];
    endsequence
    // instruction reload lands one edge after reset state is reached
    a_tms_reset: assert property (@(posedge tck) disable iff (!trst_n || srst)
        s_five_high |-> ##2 (!core_sel && !pin_oe && !core_test_en))
        else $error("mode-select reset missed");
    a_oe_after_low: assert property (@(posedge tck) disable iff (!trst_n)
        tdo_out.oe |-> !$past(tms))
        else $error("output driven outside shift");
    a_oe_holds: assert property (@(posedge tck) disable iff (!trst_n)
        tdo_out.oe && !tms |=> tdo_out.oe)
        else $error("output dropped in shift");
    a_oe_drops: assert property (@(posedge tck) disable iff (!trst_n)
        tdo_out.oe && tms |=> !tdo_out.oe)
        else $error("output kept after shift");
    a_trst_clears: assert property (@(posedge clk_sys) disable iff (srst)
        !trst_n |-> (tdo_out == 2'h0 && !core_sel && !pin_oe && !core_test_en))
        else $error("test reset did not clear");
    // srst itself is the cause here, so test reset gates it instead
    a_srst_clears: assert property (@(posedge clk_sys) disable iff (!trst_n)
        $rose(srst) |-> ##2 (!tdo_out.oe && !core_sel && !pin_oe))
        else $error("system reset did not clear");
    a_valid_pulse: assert property (@(posedge clk_sys) disable iff (srst)
        user_valid |=> !user_valid)
        else $error("valid longer than one cycle");
    a_word_valid: assert property (@(posedge clk_sys) disable iff (srst)
        !$stable(user_word) && !$past(srst) |-> user_valid)
        else $error("word changed without valid");
endmodule
bind jts_tap jts_tap_props i_props (.clk_sys(clk_sys), .srst(srst), .tck(tck),
    .trst_n(trst_n), .tms(tms), .tdo_out(tdo_out), .core_sel(core_sel), .pin_oe(pin_oe),
    .core_test_en(core_test_en), .user_word(user_word), .user_valid(user_valid));
`default_nettype wire

// ---- verif/jts_probe.sv ----
// external tester model driving the link
`timescale 1ns/1ps
`default_nettype none
module jts_probe (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire jts_pkg::jts_tdo_type tdo_out
);
    import jts_pkg::*;
    // clock stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one cycle at 48 ns; inputs move only while the clock is low
    task automatic tick(input logic m, input logic d, output logic so, output logic oe);
        tms = m;
        tdi = d;
        #24 tck = 1'b1;
        // a released line floats to its pull-up level
        so = tdo_out.oe ? tdo_out.tdo : 1'b1;
        oe = tdo_out.oe;
        #24 tck = 1'b0;
    endtask
    // five high cycles reach reset from anywhere, then idle
    task automatic reset_tap;
        logic so, oe;
        repeat (5) tick(1'b1, 1'b1, so, oe);
        tick(1'b0, 1'b1, so, oe);
    endtask
    // idle to shift, n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
            output logic [31:0] dout, output logic oe_all);
        logic so, oe;
        dout = '0;
        oe_all = 1'b1;
        tick(1'b1, 1'b1, so, oe);
        if (ir) begin
            tick(1'b1, 1'b1, so, oe);
        end
        tick(1'b0, 1'b1, so, oe); // capture
        tick(1'b0, 1'b1, so, oe); // enter shift
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], so, oe);
            dout[i] = so;
            oe_all = oe_all & oe;
        end
        tick(1'b1, 1'b1, so, oe); // update
        tick(1'b0, 1'b1, so, oe);
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import jts_pkg::*;
    logic clk_sys = 1'b0, srst = 1'b1, trst_n = 1'b0, core_tdo = 1'b0;
    logic tck, tms, tdi, core_sel, pin_oe, core_test_en, user_valid, oe_all;
    logic [BSR_W-1:0] pin_in = 8'h3c, pin_out, core_test_val;
    logic [USR_W-1:0] user_word;
    logic [31:0] dout;
    jts_tdo_type tdo_out;
    int err_count = 0, n_tests = 0, cycles = 0;
    logic [3:0] byp_codes [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd, 4'hf};
    always #20 clk_sys = ~clk_sys;
    jts_probe i_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out));
    jts_tap i_dut (.clk_sys(clk_sys), .srst(srst), .tck(tck), .trst_n(trst_n), .tms(tms),
        .tdi(tdi), .tdo_out(tdo_out), .core_tdo(core_tdo), .core_sel(core_sel),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .core_test_val(core_test_val),
        .core_test_en(core_test_en), .user_word(user_word), .user_valid(user_valid));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // a hang ends the run as a mismatch
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            final_report();
        end
    end
    task automatic load_ir(input logic [3:0] c);
        i_probe.scan(1'b1, {28'h0, c}, 4, dout, oe_all);
        chk(dout[3:0], IR_CAPTURE);
    endtask
    task automatic dr(input logic [31:0] d, input int n);
        i_probe.scan(1'b0, d, n, dout, oe_all);
        chk(oe_all, 1'b1);
    endtask
    task automatic t_idcode;
        dr(32'h0, 32);
        chk(dout, IDCODE_VAL);
        chk(tdo_out.oe, 1'b0);
    endtask
    task automatic t_bypass;
        foreach (byp_codes[i]) begin
            load_ir(byp_codes[i]);
            dr(32'h1a5, 9);
            chk(dout[8:0], {8'ha5, BYP_CAPTURE});
        end
    endtask
    task automatic t_boundary;
        load_ir(INS_SAMPLE);
        dr(32'h5a, 8);
        chk(dout[7:0], pin_in);
        chk(pin_out, 8'h5a);
        load_ir(INS_EXTEST);
        chk(pin_oe, 1'b1);
        dr(32'hff, 8);
        repeat (50) @(negedge clk_sys);
        chk(pin_out, 8'h5a);
        chk(pin_oe, 1'b1);
        load_ir(INS_INTEST);
        chk({pin_oe, core_test_en, core_test_val}, 10'h15a);
    endtask
    task automatic t_core;
        for (int i = 0; i < 3; i++) begin
            load_ir(i == 0 ? INS_ABORT : i == 1 ? INS_DPACC : INS_APACC);
            chk(core_sel, 1'b1);
            @(negedge clk_sys) core_tdo = ~core_tdo;
            dr(32'h0, 8);
            chk(dout[7:0], {8{core_tdo}});
        end
        load_ir(INS_IDCODE);
        chk(core_sel, 1'b0);
    endtask
    task automatic t_user;
        load_ir(INS_USER);
        dr(32'hc3, 8);
        for (int i = 0; i < 40 && user_valid !== 1'b1; i++) begin
            @(negedge clk_sys);
        end
        chk({user_valid, user_word}, 9'h1c3);
        // park in instruction shift, the longest way back to reset
        i_probe.tick(1'b1, 1'b1, dout[0], oe_all);
        i_probe.tick(1'b1, 1'b1, dout[0], oe_all);
        i_probe.tick(1'b0, 1'b1, dout[0], oe_all);
        i_probe.tick(1'b0, 1'b1, dout[0], oe_all);
        i_probe.reset_tap();
        t_idcode();
    endtask
    // identity read with a pause half way, exit2 back into shift
    task automatic t_pause;
        logic so, oe;
        logic [31:0] got;
        got = '0;
        i_probe.tick(1'b1, 1'b1, so, oe);
        i_probe.tick(1'b0, 1'b1, so, oe);
        i_probe.tick(1'b0, 1'b1, so, oe);
        for (int i = 0; i < 32; i++) begin
            i_probe.tick(i == 15 || i == 31, 1'b0, so, oe);
            got[i] = so;
            if (i == 15) begin
                i_probe.tick(1'b0, 1'b0, so, oe);
                i_probe.tick(1'b0, 1'b0, so, oe);
                chk(oe, 1'b0);
                i_probe.tick(1'b1, 1'b0, so, oe);
                i_probe.tick(1'b0, 1'b0, so, oe);
            end
        end
        i_probe.tick(1'b1, 1'b1, so, oe);
        i_probe.tick(1'b0, 1'b1, so, oe);
        chk(got, IDCODE_VAL);
    endtask
    task automatic t_resets;
        load_ir(INS_DPACC);
        @(negedge clk_sys) srst = 1'b1;
        @(negedge clk_sys) srst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(core_sel, 1'b0);
        i_probe.reset_tap();
        load_ir(INS_DPACC);
        @(negedge clk_sys) trst_n = 1'b0;
        repeat (3) i_probe.tick(1'b0, 1'b0, dout[0], oe_all);
        chk({core_sel, tdo_out}, 3'h0);
        @(negedge clk_sys) trst_n = 1'b1;
        i_probe.reset_tap();
        t_idcode();
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        trst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        i_probe.reset_tap();
        t_idcode();
        t_bypass();
        t_boundary();
        t_core();
        t_user();
        t_pause();
        t_resets();
        final_report();
    end
endmodule
`default_nettype wire
